// ==== design/mirc_top.sv ====
/*
 Interrupt request and enable logic of a small microcontroller.
 Assumes all event inputs are synchronous one-cycle pulses or levels on
 i_clk, and a register master with one-cycle strobes and no wait states.
*/
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "mirc_map.svh"

// Overview of operation
// R1 - Pending enabled request suspends core program
// R2 - Sources: pin, timers, comparator, timebase, others
// R3 - Hardware sets flags; software owns enables
// R4 - Primary registers hold primary flags, enables
// R5 - Groups fold sub-source flags into one
// R6 - Edge field: off, rise, fall, both
// R7 - Control 0 bit layout, global enable bit 0
// R8 - Flags read pending, software may write them
// R9 - Unused bits ignore writes, read zero
// R10 - Software leaves reserved group 1 untouched
// R11 - Enabled pending flag selects source vector
// R12 - Comparator flag on result bit change
// R13 - Group flag when enabled sub flag set
// R14 - Deliver only with global, enable, flag set
module mirc_top
    import mirc_pkg::*;
#(
    parameter bit G1_ON = 1'b1
) (
    input wire logic i_clk, // System clock, 50 MHz
    input wire logic i_rstn, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes state
    input wire logic [3:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after i_rd
    input wire logic i_pin, // External interrupt pin
    input wire logic i_cmp_out, // Comparator result bit
    input wire logic i_adc_done, // Converter end pulse
    input wire logic i_tb0, // Time base 0 pulse
    input wire logic i_tb1, // Time base 1 pulse
    input wire logic i_lvd, // Low voltage pulse
    input wire logic i_eeprom, // EEPROM done pulse
    input wire logic i_serial, // Serial port unit pulse
    input wire logic [2:0] i_tmr_period, // Timer period pulses
    input wire logic [2:0] i_tmr_match_a, // Timer match A pulses
    input wire logic i_tmr_match_b, // Timer 2 match B pulse
    output logic o_core_req, // Request to core
    output logic [2:0] o_core_vec, // Source of request
    output logic o_irq // Status interrupt line
);
    // ------------------------------------------------------------------
    // Source order in the primary vectors
    // ------------------------------------------------------------------
    localparam int S_PIN = 0;
    localparam int S_CMP = 1;
    localparam int S_G0 = 2;
    localparam int S_G1 = 3;
    localparam int S_G2 = 4;
    localparam int S_ADC = 5;
    localparam int S_TB0 = 6;
    localparam int S_TB1 = 7;
    localparam mirc_byte_t M_CTRL1 = G1_ON ? `MIRC_M_CTRL1 : `MIRC_M_CTRL1_NOG1;

    mirc_byte_t edge_q;
    mirc_byte_t ctrl0_q;
    mirc_byte_t ctrl1_q;
    mirc_byte_t ctrl2_q;
    mirc_byte_t sts_q;
    mirc_byte_t ien_q;
    mirc_byte_t rd_d;
    logic [7:0] p_f;
    logic [7:0] p_e;
    logic [7:0] p_set;
    logic [7:0] pend;
    logic [2:0] vec_d;
    logic pin_ev;
    logic cmp_ev;
    logic wr_edge;
    logic wr_c0;
    logic wr_c1;
    logic wr_c2;

    mirc_grp_if #(.N(4)) g0 ();
    mirc_grp_if #(.N(3)) g1 ();
    mirc_grp_if #(.N(3)) g2 ();

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign wr_edge = i_wr && (i_addr == `MIRC_A_EDGE);
    assign wr_c0 = i_wr && (i_addr == `MIRC_A_CTRL0);
    assign wr_c1 = i_wr && (i_addr == `MIRC_A_CTRL1);
    assign wr_c2 = i_wr && (i_addr == `MIRC_A_CTRL2);

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    mirc_edge u_pin_edge (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_in(i_pin),
        .i_mode(mirc_edge_e'(edge_q[1:0])),
        .o_ev(pin_ev)
    );

    // Any change of the result bit, not of the output pin
    mirc_edge u_cmp_edge (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_in(i_cmp_out),
        .i_mode(EDGE_BOTH),
        .o_ev(cmp_ev)
    ); // R12

    assign g0.ev = {i_tmr_match_a[1], i_tmr_period[1], i_tmr_match_a[0], i_tmr_period[0]}; // R2
    assign g1.ev = {i_tmr_match_b, i_tmr_match_a[2], i_tmr_period[2]}; // R2
    assign g2.ev = {i_serial, i_eeprom, i_lvd}; // R2
    assign g0.wr = i_wr && (i_addr == `MIRC_A_GRP0);
    assign g1.wr = i_wr && (i_addr == `MIRC_A_GRP1); // R10
    assign g2.wr = i_wr && (i_addr == `MIRC_A_GRP2);
    assign g0.wdata = i_wdata;
    assign g1.wdata = i_wdata;
    assign g2.wdata = i_wdata;

    mirc_group #(.N(4), .EN(1'b1)) u_grp0 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .g(g0)
    );

    mirc_group #(.N(3), .EN(G1_ON)) u_grp1 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .g(g1)
    );

    mirc_group #(.N(3), .EN(1'b1)) u_grp2 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .g(g2)
    );

    assign p_set[S_PIN] = pin_ev;
    assign p_set[S_CMP] = cmp_ev;
    assign p_set[S_G0] = g0.req; // R13
    assign p_set[S_G1] = g1.req && G1_ON; // R13
    assign p_set[S_G2] = g2.req; // R13
    assign p_set[S_ADC] = i_adc_done;
    assign p_set[S_TB0] = i_tb0;
    assign p_set[S_TB1] = i_tb1;

    // ------------------------------------------------------------------
    // Primary registers: a set event wins over a software write
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            edge_q <= `MIRC_RST_EDGE;
        end else if (i_ce && wr_edge) begin
            edge_q <= i_wdata & `MIRC_M_EDGE; // R9
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl0_q <= `MIRC_RST_CTRL;
        end else if (i_ce) begin
            if (wr_c0) begin
                ctrl0_q <= i_wdata & `MIRC_M_CTRL0; // R8 R9 R7
            end
            if (p_set[S_PIN]) begin
                ctrl0_q[`MIRC_B_PIN_F] <= 1'b1; // R3
            end
            if (p_set[S_CMP]) begin
                ctrl0_q[`MIRC_B_CMP_F] <= 1'b1; // R12
            end
            if (p_set[S_G0]) begin
                ctrl0_q[`MIRC_B_G0_F] <= 1'b1; // R5
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl1_q <= `MIRC_RST_CTRL;
        end else if (i_ce) begin
            if (wr_c1) begin
                ctrl1_q <= i_wdata & M_CTRL1; // R8
            end
            if (p_set[S_G1]) begin
                ctrl1_q[`MIRC_B_G1_F] <= 1'b1; // R5
            end
            if (p_set[S_G2]) begin
                ctrl1_q[`MIRC_B_G2_F] <= 1'b1; // R5
            end
            if (p_set[S_ADC]) begin
                ctrl1_q[`MIRC_B_ADC_F] <= 1'b1; // R3
            end
            if (p_set[S_TB0]) begin
                ctrl1_q[`MIRC_B_TB0_F] <= 1'b1; // R3
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl2_q <= `MIRC_RST_CTRL;
        end else if (i_ce) begin
            if (wr_c2) begin
                ctrl2_q <= i_wdata & `MIRC_M_CTRL2; // R8
            end
            if (p_set[S_TB1]) begin
                ctrl2_q[`MIRC_B_TB1_F] <= 1'b1; // R3
            end
        end
    end

    // ------------------------------------------------------------------
    // Primary flag and enable vectors
    // ------------------------------------------------------------------
    assign p_f = {ctrl2_q[`MIRC_B_TB1_F], ctrl1_q[`MIRC_B_TB0_F], ctrl1_q[`MIRC_B_ADC_F],
                  ctrl1_q[`MIRC_B_G2_F], ctrl1_q[`MIRC_B_G1_F], ctrl0_q[`MIRC_B_G0_F],
                  ctrl0_q[`MIRC_B_CMP_F], ctrl0_q[`MIRC_B_PIN_F]}; // R4
    assign p_e = {ctrl2_q[`MIRC_B_TB1_EN], ctrl1_q[`MIRC_B_TB0_EN], ctrl1_q[`MIRC_B_ADC_EN],
                  ctrl1_q[`MIRC_B_G2_EN], ctrl1_q[`MIRC_B_G1_EN], ctrl0_q[`MIRC_B_G0_EN],
                  ctrl0_q[`MIRC_B_CMP_EN], ctrl0_q[`MIRC_B_PIN_EN]}; // R4
    assign pend = p_f & p_e;

    // Lowest source index wins the vector
    always_comb begin
        vec_d = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pend[i]) begin
                vec_d = 3'(i); // R11
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_req <= 1'b0;
            o_core_vec <= 3'h0;
        end else if (i_ce) begin
            o_core_req <= ctrl0_q[`MIRC_B_EMI] && (|pend); // R1 R14
            o_core_vec <= vec_d; // R11
        end
    end

    // ------------------------------------------------------------------
    // Sticky status, write-one-to-clear, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sts_q <= 8'h00;
        end else if (i_ce) begin
            if (i_wr && (i_addr == `MIRC_A_CLR)) begin
                sts_q <= (sts_q & ~i_wdata) | p_set;
            end else begin
                sts_q <= sts_q | p_set;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ien_q <= 8'h00;
        end else if (i_ce && i_wr && (i_addr == `MIRC_A_IEN)) begin
            ien_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(sts_q & ien_q);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb begin
        case (i_addr)
            `MIRC_A_EDGE: rd_d = edge_q; // R9
            `MIRC_A_CTRL0: rd_d = ctrl0_q; // R8
            `MIRC_A_CTRL1: rd_d = ctrl1_q;
            `MIRC_A_CTRL2: rd_d = ctrl2_q;
            `MIRC_A_GRP0: rd_d = g0.value;
            `MIRC_A_GRP1: rd_d = g1.value;
            `MIRC_A_GRP2: rd_d = g2.value;
            `MIRC_A_STS: rd_d = sts_q;
            `MIRC_A_IEN: rd_d = ien_q;
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rd_d : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_emi_pend;
        i_ce && ctrl0_q[`MIRC_B_EMI] && (|pend);
    endsequence

    property p_req;
        s_emi_pend |=> o_core_req;
    endproperty
    a_req: assert property (p_req) else $error("request not raised"); // R1

    property p_deliver;
        (i_ce && !ctrl0_q[`MIRC_B_EMI]) |=> !o_core_req;
    endproperty
    a_deliver: assert property (p_deliver) else $error("request without global"); // R14

    property p_vec;
        (s_emi_pend and pend[S_PIN]) |=> (o_core_vec == 3'h0) && o_core_req;
    endproperty
    a_vec: assert property (p_vec) else $error("wrong vector"); // R11

    property p_pin_set;
        (i_ce && pin_ev) |=> ctrl0_q[`MIRC_B_PIN_F];
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin flag not set"); // R3

    property p_cmp;
        (i_ce && cmp_ev) |=> ctrl0_q[`MIRC_B_CMP_F] ##1 (ctrl0_q[`MIRC_B_CMP_F] || $past(wr_c0));
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator flag lost"); // R12

    property p_sw_clr;
        (i_ce && wr_c0 && !i_wdata[`MIRC_B_PIN_F] && !pin_ev) |=> !ctrl0_q[`MIRC_B_PIN_F];
    endproperty
    a_sw_clr: assert property (p_sw_clr) else $error("flag write ignored"); // R8

    property p_emi;
        (i_ce && wr_c0) |=> ctrl0_q[`MIRC_B_EMI] == $past(i_wdata[`MIRC_B_EMI]);
    endproperty
    a_emi: assert property (p_emi) else $error("global enable wrong"); // R7

    property p_res;
        (i_ce && i_rd && i_addr == `MIRC_A_EDGE) |=> (o_rdata[7:2] == 6'h00);
    endproperty
    a_res: assert property (p_res) else $error("reserved bits nonzero"); // R9

    property p_grp;
        (i_ce && g0.req) |=> ctrl0_q[`MIRC_B_G0_F];
    endproperty
    a_grp: assert property (p_grp) else $error("group flag not set"); // R13
endmodule // mirc_top

// ==== design/mirc_map.svh ====
/*
 Register offsets, bit positions, masks and reset values of the interrupt
 request block. Assumes it is included by bare name before the package import.
*/
`ifndef MIRC_MAP_SVH
`define MIRC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MIRC_A_EDGE 4'h0
`define MIRC_A_CTRL0 4'h1
`define MIRC_A_CTRL1 4'h2
`define MIRC_A_CTRL2 4'h3
`define MIRC_A_GRP0 4'h4
`define MIRC_A_GRP1 4'h5
`define MIRC_A_GRP2 4'h6
`define MIRC_A_STS 4'h7
`define MIRC_A_CLR 4'h8
`define MIRC_A_IEN 4'h9

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define MIRC_B_EMI 0
`define MIRC_B_PIN_EN 1
`define MIRC_B_CMP_EN 2
`define MIRC_B_G0_EN 3
`define MIRC_B_PIN_F 4
`define MIRC_B_CMP_F 5
`define MIRC_B_G0_F 6
`define MIRC_B_G1_EN 0
`define MIRC_B_G2_EN 1
`define MIRC_B_ADC_EN 2
`define MIRC_B_TB0_EN 3
`define MIRC_B_G1_F 4
`define MIRC_B_G2_F 5
`define MIRC_B_ADC_F 6
`define MIRC_B_TB0_F 7
`define MIRC_B_TB1_EN 0
`define MIRC_B_TB1_F 4
`define MIRC_B_SUB_F 4

// ----------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------
`define MIRC_M_EDGE 8'h03
`define MIRC_M_CTRL0 8'h7f
`define MIRC_M_CTRL1 8'hff
`define MIRC_M_CTRL1_NOG1 8'hee
`define MIRC_M_CTRL2 8'h11
`define MIRC_RST_EDGE 8'h03
`define MIRC_RST_CTRL 8'h00

`endif

// ==== design/mirc_pkg.sv ====
/*
 Types of the interrupt request block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mirc_pkg;
    typedef logic [7:0] mirc_byte_t;
    typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} mirc_edge_e;
endpackage

// ==== design/mirc_grp_if.sv ====
/*
 Carrier between the top and one sub-source group.
 Assumes the top drives events and bus writes, the group answers.
*/
`timescale 1ns/1ps
interface mirc_grp_if #(parameter int N = 4);
    logic [N-1:0] ev;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] value;
    logic req;
    modport top (output ev, output wr, output wdata, input value, input req);
    modport grp (input ev, input wr, input wdata, output value, output req);
endinterface

// ==== design/mirc_edge.sv ====
/*
 Selectable edge detector for a synchronous level.
 Assumes the input is already synchronous to i_clk.
*/
`timescale 1ns/1ps
module mirc_edge
    import mirc_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_rstn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_in, // Watched level
    input wire mirc_edge_e i_mode, // Edges to report
    output logic o_ev // One-cycle edge pulse
);
    logic prev_q;
    logic vld_q;
    logic rise;
    logic fall;

    // No edge is reported before the first sample after reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_q <= 1'b0;
            vld_q <= 1'b0;
        end else if (i_ce) begin
            prev_q <= i_in;
            vld_q <= 1'b1;
        end
    end

    assign rise = vld_q & i_in & ~prev_q;
    assign fall = vld_q & ~i_in & prev_q;

    always_comb begin
        case (i_mode) // R6
            EDGE_RISE: o_ev = rise;
            EDGE_FALL: o_ev = fall;
            EDGE_BOTH: o_ev = rise | fall;
            default: o_ev = 1'b0;
        endcase
    end

    property p_edge_off;
        @(posedge i_clk) disable iff (!i_rstn) (i_mode == EDGE_OFF) |-> !o_ev;
    endproperty
    a_edge_off: assert property (p_edge_off) else $error("edge seen while off"); // R6
endmodule // mirc_edge

// ==== design/mirc_group.sv ====
/*
 One multi-function group: per sub-source flag and enable bits.
 Assumes flags at bits 4 up, enables at bits 0 up; EN low makes it reserved.
*/
`timescale 1ns/1ps
`include "mirc_map.svh"
module mirc_group
    import mirc_pkg::*;
#(
    parameter int N = 4,
    parameter bit EN = 1'b1
) (
    input wire logic i_clk, // System clock
    input wire logic i_rstn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    mirc_grp_if.grp g // Group carrier
);
    logic [N-1:0] flag_q;
    logic [N-1:0] en_q;

    if (N < 1 || N > 4) begin : g_chk
        $error("mirc_group: N must be 1 to 4");
    end

    for (genvar i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                flag_q[i] <= 1'b0;
                en_q[i] <= 1'b0;
            end else if (i_ce && EN) begin
                if (g.wr) begin
                    flag_q[i] <= g.wdata[`MIRC_B_SUB_F+i]; // R8
                    en_q[i] <= g.wdata[i];
                end
                if (g.ev[i]) begin
                    flag_q[i] <= 1'b1; // R5
                end
            end
        end
    end

    always_comb begin
        g.value = 8'h00;
        g.value[`MIRC_B_SUB_F +: N] = flag_q;
        g.value[N-1:0] = en_q;
    end

    assign g.req = |(flag_q & en_q); // R13

    property p_grp_set;
        @(posedge i_clk) disable iff (!i_rstn) (i_ce && EN && g.ev[0]) |=> flag_q[0];
    endproperty
    a_grp_set: assert property (p_grp_set) else $error("sub flag not set"); // R5
endmodule // mirc_group

// ==== test/mirc_periph_model.sv ====
/*
 Model of the peripheral side: event pulses, the pin level and the comparator bit.
 Assumes the bench calls fire() and that all events are synchronous to i_clk.
*/
`timescale 1ns/1ps
module mirc_periph_model (
    input wire logic i_clk, // System clock
    output logic [14:0] o_ev // 0 pin, 1 comparator bit, 2 up one-cycle pulses
);
    initial o_ev = '0;

    // ------------------------------------------------------------
    // Event generation
    // ------------------------------------------------------------
    // Levels toggle and hold; pulse sources drop after one cycle
    task automatic fire(input int k);
        @(posedge i_clk);
        if (k < 2) begin
            o_ev[k] <= ~o_ev[k];
        end else begin
            o_ev[k] <= 1'b1;
            @(posedge i_clk);
            o_ev[k] <= 1'b0;
        end
    endtask
endmodule // mirc_periph_model

// ==== test/mirc_top_tb.sv ====
/*
 Self-checking bench of the interrupt request block against a register model.
 Assumes the design files and the peripheral model are compiled first.
*/
`timescale 1ns/1ps
module mirc_top_tb;
    logic i_clk, i_rstn, i_ce, i_wr, i_rd, o_core_req, o_irq;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, lfsr_q;
    logic [2:0] o_core_vec;
    logic [14:0] ev;
    int error_cnt = 0;
    int tests_run = 0;
    int m[10];
    int m_sav[10];
    int msk[10] = '{3, 127, 255, 17, 255, 119, 119, 0, 0, 255};
    // Source index to register, flag bit and enable bit
    int fr[8] = '{1, 1, 1, 2, 2, 2, 2, 3};
    int fb[8] = '{4, 5, 6, 4, 5, 6, 7, 4};
    int eb[8] = '{1, 2, 3, 0, 1, 2, 3, 0};
    // Event line to register and bit; register 0 means primary source index
    int kr[15] = '{0, 0, 0, 0, 0, 6, 6, 6, 4, 4, 5, 4, 4, 5, 5};
    int kb[15] = '{0, 1, 5, 6, 7, 4, 5, 6, 4, 6, 4, 5, 7, 5, 6};

    mirc_periph_model pm (.i_clk(i_clk), .o_ev(ev));
    // Group 1 implemented, so software may use it
    mirc_top #(.G1_ON(1'b1)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(ev[0]), .i_cmp_out(ev[1]),
        .i_adc_done(ev[2]), .i_tb0(ev[3]), .i_tb1(ev[4]), .i_lvd(ev[5]), .i_eeprom(ev[6]),
        .i_serial(ev[7]), .i_tmr_period(ev[10:8]), .i_tmr_match_a(ev[13:11]),
        .i_tmr_match_b(ev[14]), .o_core_req(o_core_req), .o_core_vec(o_core_vec),
        .o_irq(o_irq)
    );

    // ------------------------------------------------------------
    // Model and checking
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic void set_src(input int i);
        m[fr[i]] |= 1 << fb[i];
        m[7] |= 1 << i;
    endfunction

    function automatic void upd_grp();
        for (int g = 0; g < 3; g++) begin
            if (((m[4 + g] >> 4) & m[4 + g] & 15) != 0) set_src(2 + g);
        end
    endfunction

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        if (a == 4'h8) m[7] &= ~int'(d);
        else if (a != 4'h7 && a < 4'ha) m[a] = d & msk[a];
        upd_grp();
    endtask

    task automatic rdc(input logic [3:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", o_rdata, (a < 4'ha) ? 8'(m[a]) : 8'h00);
    endtask

    task automatic chk_out();
        logic [7:0] pend;
        logic [2:0] v;
        logic req;
        pend = '0;
        v = '0;
        repeat (3) @(posedge i_clk);
        #1;
        for (int i = 7; i >= 0; i--) begin
            if ((((m[fr[i]] >> fb[i]) & (m[fr[i]] >> eb[i])) & 1) != 0) begin
                pend[i] = 1'b1;
                v = 3'(i);
            end
        end
        req = ((m[1] & 1) != 0) && (pend != 0);
        chk("core_req", {7'h0, o_core_req}, {7'h0, req});
        if (req) chk("core_vec", {5'h0, o_core_vec}, {5'h0, v});
        chk("irq", {7'h0, o_irq}, {7'h0, (m[7] & m[9]) != 0});
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        i_rstn = 1'b0;
        i_ce = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        lfsr_q = 8'h0a;
        m = '{3, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int a = 0; a < 16; a++) rdc(4'(a));
        wr(4'h0, 8'hff);
        wr(4'h1, 8'hff);
        wr(4'h7, 8'hff);
        for (int a = 0; a < 8; a++) rdc(4'(a));
        chk_out();
        wr(4'h1, 8'h00);
        wr(4'h8, 8'hff);
        rdc(4'h7);
        for (int md = 0; md < 4; md++) begin
            wr(4'h0, 8'(md));
            for (int s = 0; s < 2; s++) begin
                pm.fire(0);
                if (md[s]) set_src(0);
                chk_out();
                rdc(4'h1);
                wr(4'h1, 8'h00);
            end
        end
        wr(4'h8, 8'hff);
        wr(4'h4, 8'h02);
        wr(4'h5, 8'h00);
        wr(4'h6, 8'h07);
        wr(4'h1, 8'h0f);
        wr(4'h2, 8'h0f);
        wr(4'h3, 8'h01);
        wr(4'h9, 8'hff);
        for (int k = 1; k < 15; k++) begin
            pm.fire(k);
            if (kr[k] == 0) set_src(kb[k]);
            else m[kr[k]] |= 1 << kb[k];
            upd_grp();
            chk_out();
            for (int a = 1; a < 8; a++) rdc(4'(a));
        end
        for (int n = 0; n < 12; n++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(4'h1, (8'(m[1]) & 8'h70) | (lfsr_q & 8'h0f));
            wr(4'h2, (8'(m[2]) & 8'hf0) | (lfsr_q >> 4));
            wr(4'h3, (8'(m[3]) & 8'h10) | {7'h0, lfsr_q[7]});
            wr(4'h9, lfsr_q ^ 8'h5a);
            chk_out();
        end
        for (int a = 6; a > 0; a--) wr(4'(a), 8'h00);
        wr(4'h8, 8'hff);
        for (int a = 1; a < 10; a++) rdc(4'(a));
        // Frozen clock enable: write and event are both lost
        m_sav = m;
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(4'h1, 8'h0f);
        pm.fire(3);
        i_ce <= 1'b1;
        m = m_sav;
        for (int a = 1; a < 8; a++) rdc(4'(a));
        chk_out();
        report_and_stop();
    end
endmodule // mirc_top_tb
